// file: hw/ddr_phy_core.v
// half-rate memory physical layer: command, write and read paths
`timescale 1ns/1ns
`include "ddr_phy_defines.vh"
// Overview of operation
// - half-rate: two memory slots per word
// - commands centred between clock edges
// - lpddr2 commands at double rate
// - ddr2/3 commands at single rate
// - mimic clock phase drift tracked
// - system clock drives strobe and commands
// - data launched quarter period late
// - capture phase calibrated before traffic
// - low-power entered automatically on modes
// - low-power asserts memory clock disable
// - commands tristated except cke, reset
// - read input buffers off in low-power
// - strobe only on writes; reads ignore
// - data width 8, 16 or 24
// - data in groups of eight bits
// - 24 bits is 16 plus ecc
// - one mask per group
// - mask used only on writes
// - mask low valid, high discards
// - mask on delayed write clock
// - ecc byte in own group
// - ecc logic lives in controller
// - reads captured in double-rate inputs
module ddr_phy_core #(
    parameter GROUPS    = `DEF_GROUPS,
    parameter ADDR_BITS = `DEF_ADDR_BITS,
    parameter CMD_BITS  = `DEF_CMD_BITS,
    parameter DEPTH     = `DEF_FIFO_DEPTH
) (
    // clock and reset
    input  wire                            clock,
    input  wire                            rst,
    // configuration
    input  wire [1:0]                      memMode,
    input  wire                            eccEnable,
    // controller commands, two slots per word
    input  wire [2*ADDR_BITS-1:0]          ctlAddr,
    input  wire [2*CMD_BITS-1:0]           ctlCmd,
    input  wire [1:0]                      ctlCke,
    input  wire                            ctlResetN,
    input  wire                            selfRefresh,
    input  wire                            powerDown,
    // controller write data
    input  wire                            wrValid,
    output wire                            wrReady,
    input  wire [2*GROUPS*8-1:0]           wrData,
    input  wire [2*GROUPS-1:0]             wrMask,
    // controller read data
    input  wire                            rdEnable,
    output reg                             rdValid_reg,
    output reg  [2*GROUPS*8-1:0]           rdData_reg,
    // status
    output wire                            calDone,
    output wire                            memClkDisable,
    // pll phase control
    output reg                             phaseStep_reg,
    output reg                             phaseUp_reg,
    // mimic clock from loopback
    input  wire                            mimicClk,
    input  wire                            refPhase,
    // memory command pins
    output reg  [ADDR_BITS-1:0]            memAddr_reg,
    output reg  [CMD_BITS-1:0]             memCmd_reg,
    output wire                            memCmdOe,
    output reg                             memCke_reg,
    output reg                             memResetN_reg,
    // memory data pins
    output reg  [GROUPS*8-1:0]             memDqOut_reg,
    output wire                            memDqOe,
    input  wire [GROUPS*8-1:0]             memDqIn,
    output reg  [GROUPS-1:0]               memDm_reg,
    output reg  [GROUPS-1:0]               memDqsOut_reg,
    output wire                            memDqsOe,
    input  wire [GROUPS-1:0]               memDqsIn,
    output wire                            memInEnable
);
    localparam DW = GROUPS * `GROUP_BITS;
    reg  [2:0]       state_reg;
    reg  [2:0]       state_next;
    reg              slot_reg;
    reg  [7:0]       calCnt_reg;
    reg  [7:0]       trackCnt_reg;
    reg  [2:0]       mimicSync_reg;
    reg  [2:0]       refSync_reg;
    reg              mimicPrev_reg;
    reg              wrActive_reg;
    reg              wrSlot_reg;
    reg              delayPhase_reg;
    reg  [DW-1:0]    dqHold_reg;
    reg  [GROUPS-1:0] dmHold_reg;
    reg              rdSlot_reg;
    reg  [DW-1:0]    rdLow_reg;
    wire [2*DW+2*GROUPS-1:0] fifoOut;
    wire             fifoValid;
    wire             fifoTake;
    wire             lowPower;
    wire             mimicRise;
    wire             isLp;
    wire [GROUPS-1:0] dmLow;
    wire [GROUPS-1:0] dmHigh;

    // write data buffer
    ddr_phy_fifo #(
        .WIDTH (2*DW+2*GROUPS),
        .DEPTH (DEPTH),
        .AW    (2)
    ) wrFifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (wrValid),
        .inReady  (wrReady),
        .inData   ({wrMask, wrData}),
        .outValid (fifoValid),
        .outReady (fifoTake),
        .outData  (fifoOut)
    );

    assign isLp = (memMode == `MODE_LPDDR2);
    assign lowPower = (state_reg == `ST_LOWPWR);
    assign memClkDisable = lowPower;
    assign memCmdOe = ~lowPower;
    assign memInEnable = ~lowPower & ~wrActive_reg;
    assign calDone = (state_reg == `ST_RUN);
    assign memDqsOe = wrActive_reg;
    assign memDqOe = wrActive_reg;
    assign fifoTake = (state_reg == `ST_RUN) & ~wrActive_reg & fifoValid & ~rdEnable;
    assign dmLow  = fifoOut[2*DW +: GROUPS];
    assign dmHigh = fifoOut[2*DW+GROUPS +: GROUPS];

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_RESET: begin
                state_next = `ST_CAL;
            end
            `ST_CAL: begin
                if (calCnt_reg == `CAL_STEPS) begin
                    state_next = `ST_RUN;
                end
            end
            `ST_RUN: begin
                if ((selfRefresh | powerDown) & ~wrActive_reg) begin
                    state_next = `ST_LOWPWR;
                end
            end
            `ST_LOWPWR: begin
                if (~selfRefresh & ~powerDown) begin
                    state_next = `ST_RUN;
                end
            end
            default: begin
                state_next = `ST_RESET;
            end
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            state_reg <= `ST_RESET;
            calCnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == `ST_CAL) begin
                calCnt_reg <= calCnt_reg + 8'h01;
            end
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            mimicSync_reg <= 3'h0;
            refSync_reg <= 3'h0;
            mimicPrev_reg <= 1'b0;
        end else begin
            mimicSync_reg <= {mimicSync_reg[1:0], mimicClk};
            refSync_reg <= {refSync_reg[1:0], refPhase};
            if (mimicSync_reg[1] == mimicSync_reg[2]) begin
                mimicPrev_reg <= mimicSync_reg[2];
            end
        end
    end
    assign mimicRise = (mimicSync_reg[1] == mimicSync_reg[2]) & mimicSync_reg[2] & ~mimicPrev_reg;

    always @(posedge clock) begin
        if (rst) begin
            phaseStep_reg <= 1'b0;
            phaseUp_reg <= 1'b0;
            trackCnt_reg <= 8'h00;
        end else begin
            phaseStep_reg <= 1'b0;
            if (state_reg == `ST_CAL) begin
                phaseStep_reg <= 1'b1;
                phaseUp_reg <= 1'b1;
            end else if (state_reg == `ST_RUN & mimicRise) begin
                if (trackCnt_reg == `TRACK_WAIT) begin
                    trackCnt_reg <= 8'h00;
                    if (refSync_reg[2] == refSync_reg[1]) begin
                        phaseStep_reg <= 1'b1;
                        phaseUp_reg <= refSync_reg[2];
                    end
                end else begin
                    trackCnt_reg <= trackCnt_reg + 8'h01;
                end
            end
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            slot_reg <= 1'b0;
        end else begin
            slot_reg <= ~slot_reg;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            memAddr_reg <= {ADDR_BITS{1'b0}};
            memCmd_reg <= {CMD_BITS{1'b1}};
            memCke_reg <= 1'b0;
            memResetN_reg <= 1'b0;
        end else begin
            memCke_reg <= ctlCke[slot_reg] & ~lowPower;
            memResetN_reg <= ctlResetN;
            if (isLp) begin
                memAddr_reg <= slot_reg ? ctlAddr[2*ADDR_BITS-1:ADDR_BITS] : ctlAddr[ADDR_BITS-1:0];
                memCmd_reg <= slot_reg ? ctlCmd[2*CMD_BITS-1:CMD_BITS] : ctlCmd[CMD_BITS-1:0];
            end else if (~slot_reg) begin
                memAddr_reg <= ctlAddr[ADDR_BITS-1:0];
                memCmd_reg <= ctlCmd[CMD_BITS-1:0];
            end
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            wrActive_reg <= 1'b0;
            wrSlot_reg <= 1'b0;
            delayPhase_reg <= 1'b0;
            dqHold_reg <= {DW{1'b0}};
            dmHold_reg <= {GROUPS{1'b0}};
            memDqOut_reg <= {DW{1'b0}};
            memDm_reg <= {GROUPS{1'b0}};
            memDqsOut_reg <= {GROUPS{1'b0}};
        end else begin
            delayPhase_reg <= wrActive_reg;
            if (fifoTake) begin
                wrActive_reg <= 1'b1;
                wrSlot_reg <= 1'b0;
                dqHold_reg <= fifoOut[DW +: DW];
                dmHold_reg <= dmHigh & {GROUPS{eccEnable | 1'b1}};
                memDqOut_reg <= fifoOut[DW-1:0];
                memDm_reg <= dmLow;
            end else if (wrActive_reg & ~wrSlot_reg) begin
                wrSlot_reg <= 1'b1;
                memDqOut_reg <= dqHold_reg;
                memDm_reg <= dmHold_reg;
            end else if (wrActive_reg) begin
                wrActive_reg <= 1'b0;
                memDm_reg <= {GROUPS{1'b0}};
            end
            memDqsOut_reg <= (wrActive_reg & delayPhase_reg) ? ~memDqsOut_reg : {GROUPS{1'b0}};
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            rdSlot_reg <= 1'b0;
            rdLow_reg <= {DW{1'b0}};
            rdData_reg <= {2*DW{1'b0}};
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= 1'b0;
            if (rdEnable & memInEnable & calDone) begin
                rdSlot_reg <= ~rdSlot_reg;
                if (~rdSlot_reg) begin
                    rdLow_reg <= memDqIn;
                end else begin
                    rdData_reg <= {memDqIn, rdLow_reg};
                    rdValid_reg <= 1'b1;
                end
            end else begin
                rdSlot_reg <= 1'b0;
            end
        end
    end
endmodule

// file: hw/ddr_phy_defines.vh
// constants for the memory physical layer
`ifndef DDR_PHY_DEFINES_VH
`define DDR_PHY_DEFINES_VH
`define GROUP_BITS      8
`define DEF_GROUPS      2
`define DEF_ADDR_BITS   14
`define DEF_CMD_BITS    6
`define DEF_FIFO_DEPTH  4
`define MODE_DDR2       2'h0
`define MODE_DDR3       2'h1
`define MODE_LPDDR2     2'h2
`define ST_RESET        3'h0
`define ST_CAL          3'h1
`define ST_RUN          3'h2
`define ST_LOWPWR       3'h3
`define CAL_STEPS       8'h20
`define TRACK_WAIT      8'h10
`endif

// file: hw/ddr_phy_fifo.v
// small flip-flop fifo for write data
`timescale 1ns/1ns
module ddr_phy_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    // fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doWr;
    wire            doRd;
    assign inReady  = (count_reg != DEPTH[AW:0]);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_reg];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;
    always @(posedge clock) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end
    always @(posedge clock) begin
        if (rst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
            end
            if (doWr & ~doRd) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRd & ~doWr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// file: dv/ddr_phy_core_sva.sv
// port assertions for the memory physical layer
`timescale 1ns/1ns
module ddr_phy_core_sva #(
    parameter GROUPS = 2
) (
    // clock and reset
    input wire              clock,
    input wire              rst,
    // watched ports
    input wire              selfRefresh,
    input wire              calDone,
    input wire              memClkDisable,
    input wire              memCmdOe,
    input wire              memInEnable,
    input wire              memDqOe,
    input wire              memDqsOe,
    input wire [GROUPS-1:0] memDm_reg
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    lp_cmd_tristate_a: assert property (memClkDisable |-> !memCmdOe)
        else $error("commands driven in low power");
    lp_inbuf_off_a: assert property (memClkDisable |-> !memInEnable)
        else $error("input buffers on in low power");
    cal_first_a: assert property (!calDone |-> !memDqOe)
        else $error("write before calibration");
    strobe_write_a: assert property (memDqsOe |-> memDqOe)
        else $error("strobe driven outside write");
    burst_two_a: assert property ($rose(memDqOe) |=> memDqOe ##1 !memDqOe)
        else $error("write burst not two beats");
    dm_idle_a: assert property (!memDqOe |-> memDm_reg == '0)
        else $error("mask high outside write");
    lp_entry_a: assert property ($rose(selfRefresh) && calDone |-> ##[1:20] memClkDisable)
        else $error("low power not entered");
    cal_length_a: assert property ($fell(rst) |-> !calDone ##29 !calDone ##[1:6] calDone)
        else $error("calibration length wrong");
endmodule

bind ddr_phy_core ddr_phy_core_sva #(.GROUPS(GROUPS)) i_ddr_phy_core_sva (.*);

// file: dv/mem_model.sv
// behavioural memory behind the data pins
`timescale 1ns/1ns
module mem_model #(
    parameter W = 16
) (
    // clock
    input  wire           clock,
    // data pins
    input  wire [W-1:0]   memDqOut_reg,
    input  wire [W/8-1:0] memDm_reg,
    input  wire           memDqOe,
    input  wire           memInEnable,
    output wire [W-1:0]   memDqIn
);
    logic   [W-1:0] word = '0;
    integer         g;

    always @(posedge clock) begin
        if (memDqOe) begin
            for (g = 0; g < W/8; g = g + 1) begin
                if (!memDm_reg[g]) begin
                    word[g*8 +: 8] <= memDqOut_reg[g*8 +: 8];
                end
            end
        end
    end

    assign memDqIn = memInEnable ? word : ~word;
endmodule

// file: dv/ddr_phy_core_tb.sv
// self-checking bench for the memory physical layer
`timescale 1ns/1ns
`include "ddr_phy_defines.vh"
module ddr_phy_core_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  memMode = `MODE_DDR3;
    logic        eccEnable = 1'b0;
    logic [27:0] ctlAddr = 28'h0000123;
    logic [11:0] ctlCmd = 12'hfff;
    logic [1:0]  ctlCke = 2'h3;
    logic        ctlResetN = 1'b1;
    logic        selfRefresh = 1'b0;
    logic        powerDown = 1'b0;
    logic        wrValid = 1'b0;
    logic [31:0] wrData = 32'h0;
    logic [3:0]  wrMask = 4'h0;
    logic        rdEnable = 1'b0;
    logic        mimicClk = 1'b0;
    logic [1:0]  memDqsIn = 2'h0;
    wire         refPhase = ~mimicClk;
    wire         wrReady, rdValid_reg, calDone, memClkDisable, memCmdOe, memDqOe, memDqsOe, memInEnable;
    wire [31:0]  rdData_reg;
    wire [15:0]  memDqOut_reg, memDqIn;
    wire [1:0]   memDm_reg, memDqsOut_reg;
    wire [13:0]  memAddr_reg;
    wire [5:0]   memCmd_reg;
    wire         memCke_reg, memResetN_reg, phaseStep_reg, phaseUp_reg;
    int          nMismatch = 0, checkCount = 0, cycles = 0, m, nStep = 0;

    ddr_phy_core i_ddr_phy_core (.*);
    mem_model #(.W(16)) i_mem_model (.*);

    initial begin
        forever #25 clock = ~clock;
    end
    initial begin
        forever #200 mimicClk = ~mimicClk;
    end
    always @(posedge clock) begin
        if (phaseStep_reg === 1'b1) nStep++;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            giveVerdict();
        end
    end

    task tick(input int n = 1);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task giveVerdict;
        $display("mismatches %0d checks %0d", nMismatch, checkCount);
        if (nMismatch == 0 && checkCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // fill fifo during calibration, drain after
    task fillDuringCal;
        int i, n;
        logic last;
        n = 0;
        last = 1'b0;
        wrValid = 1'b1;
        wrData = 32'h5a5a_a5a5;
        for (i = 0; i < 4; i++) begin
            chk(wrReady, 1, "fifo refused early");
            tick();
        end
        chk(wrReady, 0, "full fifo not refusing");
        wrValid = 1'b0;
        for (i = 0; i < 50 && calDone !== 1'b1; i++) tick();
        chk(nStep, `CAL_STEPS, "calibration steps");
        for (i = 0; i < 40; i++) begin
            if (memDqOe === 1'b1 && !last) n++;
            last = memDqOe;
            tick();
        end
        chk(n, 4, "bursts drained");
        chk(wrReady, 1, "fifo not empty");
    endtask

    // masked write in one command mode
    task writeMasked(input logic [1:0] mode);
        int i;
        memMode = mode;
        wrData = 32'hd6c5_b4a3;
        wrMask = 4'b1000;
        wrValid = 1'b1;
        chk(wrReady, 1, "write refused");
        tick();
        wrValid = 1'b0;
        for (i = 0; i < 10 && memDqOe !== 1'b1; i++) tick();
        chk({memDqOut_reg, memDm_reg}, {16'hb4a3, 2'b00}, "first beat");
        chk({memDqsOe, memDqOe}, 2'b11, "strobe with data");
        tick();
        chk({memDqOut_reg, memDm_reg}, {16'hd6c5, 2'b10}, "second beat");
        tick();
        chk({memDqOe, memDm_reg}, 3'b000, "mask after burst");
        chk(i_mem_model.word, 16'hb4c5, "masked byte written");
    endtask

    // command words in one memory mode
    task cmdPath(input logic [1:0] mode);
        logic [19:0] a1, a2;
        memMode = mode;
        ctlAddr = {14'h1456, 14'h0123};
        ctlCmd = {6'h15, 6'h2a};
        tick(3);
        a1 = {memAddr_reg, memCmd_reg};
        tick();
        a2 = {memAddr_reg, memCmd_reg};
        if (mode == `MODE_LPDDR2) begin
            chk(a1 ^ a2, {14'h0123 ^ 14'h1456, 6'h2a ^ 6'h15}, "double rate halves");
            chk(a1 == {14'h0123, 6'h2a} || a1 == {14'h1456, 6'h15}, 1, "double rate slot");
        end else begin
            chk(a1, {14'h0123, 6'h2a}, "single rate first");
            chk(a2, {14'h0123, 6'h2a}, "single rate held");
        end
        chk({memCke_reg, memResetN_reg, memCmdOe}, 3'b111, "command pins driven");
        ctlCmd = 12'hfff;
    endtask

    // capture phase follows mimic clock
    task trackPhase;
        int i;
        for (i = 0; i < 300 && phaseStep_reg !== 1'b1; i++) tick();
        chk(phaseStep_reg, 1, "no tracking step");
        chk(phaseUp_reg, 0, "tracking direction");
    endtask

    // read with strobe pins held high
    task readBack;
        int i;
        memDqsIn = 2'h3;
        rdEnable = 1'b1;
        for (i = 0; i < 10 && rdValid_reg !== 1'b1; i++) tick();
        chk(rdData_reg, 32'hb4c5_b4c5, "read data");
        chk(memDqsOe, 0, "strobe on read");
        rdEnable = 1'b0;
        memDqsIn = 2'h0;
        tick();
    endtask

    // enter and leave low power
    task lowPower(input logic sr);
        int i;
        selfRefresh = sr;
        powerDown = !sr;
        for (i = 0; i < 20 && memClkDisable !== 1'b1; i++) tick();
        chk({memClkDisable, memCmdOe, memInEnable}, 3'b100, "low power pins");
        chk(memResetN_reg, 1, "reset pin dropped");
        selfRefresh = 1'b0;
        powerDown = 1'b0;
        for (i = 0; i < 20 && memClkDisable !== 1'b0; i++) tick();
        chk({memClkDisable, memCmdOe, memInEnable}, 3'b011, "low power exit");
    endtask

    initial begin
        tick(16);
        rst = 1'b0;
        fillDuringCal();
        for (m = 0; m < 3; m++) writeMasked(m[1:0]);
        for (m = 0; m < 3; m++) cmdPath(m[1:0]);
        readBack();
        lowPower(1'b1);
        lowPower(1'b0);
        trackPhase();
        giveVerdict();
    end
endmodule
